/* prbs_defs.vh */
// constants for the processor reset and boot sequencer
`ifndef PRBS_DEFS_VH
`define PRBS_DEFS_VH
`define PRBS_CFG_SETTLE 8'd20
`define PRBS_MIN_RESET 16'd400
`define PRBS_ICACHE_SELF_TEST_CYCLES 16'd64
`define PRBS_SROM_WORDS 16'd32
`define PRBS_RESET_VECTOR 40'h00_0000_0000
`define PRBS_CFG_W 7
`endif

/* prbs_icache_self_test.v */
// instruction-cache self-test engine: LFSR signature run for CYCLES cycles
module prbs_icache_self_test #(
  parameter CYCLES = 64
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire start,
  output reg busy,
  output reg done,
  output reg pass
);
  reg [15:0] count;
  reg [7:0] lfsr;
  always @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      count <= 16'h0000;
      lfsr <= 8'h01;
    end else if (ce) begin
      if (start && !busy) begin
        busy <= 1'b1;
        done <= 1'b0;
        count <= 16'h0000;
        lfsr <= 8'h01;
      end else if (busy) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        if (count == CYCLES[15:0] - 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
          // signature never collapses to zero in a healthy array
          pass <= (lfsr != 8'h00);
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
endmodule

/* prbs_sequencer.v */
// reset, clock source and boot sequencing for the processor
`include "prbs_defs.vh"
module prbs_sequencer #(
  parameter ICACHE_SELF_TEST_CYCLES = 64,
  parameter SROM_WORDS = 32
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire power_good_in,
  input wire sys_reset_n,
  input wire [`PRBS_CFG_W-1:0] irq_cfg_in,
  input wire srom_present_n,
  input wire srom_data_in,
  input wire icache_flush_control,
  input wire fetch_hit_in,
  output reg cpu_reset,
  output reg use_ring_osc,
  output reg pins_weak_pull,
  output reg bus_oe,
  output reg ram_oe_n,
  output reg ram_we_n,
  output reg strobe_n,
  output reg advance_n,
  output reg test_clock_out_a,
  output reg test_clock_out_b,
  output reg test_clock_out_c,
  output reg bus_clock_output_a,
  output reg bus_clock_output_b,
  output reg srom_clk_out,
  output reg srom_oe_n,
  output reg test_status_out,
  output reg icache_self_test_status,
  output reg [`PRBS_CFG_W-1:0] clk_cfg,
  output reg cfg_valid,
  output reg icache_valid,
  output reg fetch_req,
  output reg offchip_read,
  output reg [39:0] fetch_addr,
  output reg boot_done
);
  localparam S_RESET = 5'b00001;
  localparam S_ICACHE_SELF_TEST = 5'b00010;
  localparam S_SROM = 5'b00100;
  localparam S_DISP = 5'b01000;
  localparam S_RUN = 5'b10000;

  reg pg_s1, pg_s2, rs_s1, rs_s2, sp_s1, sp_s2, sd_s1, sd_s2;
  reg [`PRBS_CFG_W-1:0] cfg_s1, cfg_s2;
  reg [4:0] state;
  reg [7:0] settle;
  reg [15:0] words;
  reg [3:0] div;
  reg srom_sel;
  reg icache_self_test_start;
  wire icache_self_test_busy, icache_self_test_done, icache_self_test_pass;
  wire in_reset;

  // power good, reset, serial ROM and config inputs pass two flops (flush and fetch hit do not); release timing follows sysclk edges
  always @(posedge clk_sys) begin
    if (rst) begin
      pg_s1 <= 1'b0;
      pg_s2 <= 1'b0;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
      sp_s1 <= 1'b1;
      sp_s2 <= 1'b1;
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
      cfg_s1 <= {`PRBS_CFG_W{1'b0}};
      cfg_s2 <= {`PRBS_CFG_W{1'b0}};
    end else if (ce) begin
      pg_s1 <= power_good_in;
      pg_s2 <= pg_s1;
      rs_s1 <= sys_reset_n;
      rs_s2 <= rs_s1;
      sp_s1 <= srom_present_n;
      sp_s2 <= sp_s1;
      sd_s1 <= srom_data_in;
      sd_s2 <= sd_s1;
      cfg_s1 <= irq_cfg_in;
      cfg_s2 <= cfg_s1;
    end
  end

  // board ordering of power good and reset is trusted, not policed
  assign in_reset = !pg_s2 || !rs_s2;

  prbs_icache_self_test #(
    .CYCLES(ICACHE_SELF_TEST_CYCLES)
  ) u_icache_self_test (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .start(icache_self_test_start),
    .busy(icache_self_test_busy),
    .done(icache_self_test_done),
    .pass(icache_self_test_pass)
  );

  always @(posedge clk_sys) begin
    if (rst) begin
      state <= S_RESET;
      cpu_reset <= 1'b1;
      use_ring_osc <= 1'b1;
      pins_weak_pull <= 1'b1;
      bus_oe <= 1'b0;
      ram_oe_n <= 1'b1;
      ram_we_n <= 1'b1;
      strobe_n <= 1'b1;
      advance_n <= 1'b1;
      test_clock_out_a <= 1'b0;
      test_clock_out_b <= 1'b0;
      test_clock_out_c <= 1'b0;
      bus_clock_output_a <= 1'b0;
      bus_clock_output_b <= 1'b0;
      srom_clk_out <= 1'b0;
      srom_oe_n <= 1'b1;
      test_status_out <= 1'b0;
      icache_self_test_status <= 1'b0;
      clk_cfg <= {`PRBS_CFG_W{1'b0}};
      cfg_valid <= 1'b0;
      settle <= 8'h00;
      icache_valid <= 1'b0;
      fetch_req <= 1'b0;
      offchip_read <= 1'b0;
      fetch_addr <= 40'h00_0000_0000;
      boot_done <= 1'b0;
      words <= 16'h0000;
      div <= 4'h0;
      srom_sel <= 1'b0;
      icache_self_test_start <= 1'b0;
    end else if (ce) begin
      use_ring_osc <= !pg_s2;
      pins_weak_pull <= !pg_s2 && in_reset;
      // bus clocks keep running through reset, divided by sampled ratio
      div <= div + 4'h1;
      if (div == {1'b0, clk_cfg[2:0]}) begin
        div <= 4'h0;
        bus_clock_output_a <= !bus_clock_output_a;
        bus_clock_output_b <= clk_cfg[3] ? bus_clock_output_a :
                              !bus_clock_output_a;
      end
      icache_self_test_start <= 1'b0;
      fetch_req <= 1'b0;
      if (in_reset) begin
        state <= S_RESET;
        cpu_reset <= 1'b1;
        bus_oe <= 1'b0;
        ram_oe_n <= 1'b1;
        ram_we_n <= 1'b1;
        strobe_n <= 1'b1;
        advance_n <= 1'b1;
        test_clock_out_a <= 1'b0;
        test_clock_out_b <= 1'b0;
        test_clock_out_c <= 1'b0;
        srom_clk_out <= 1'b0;
        srom_oe_n <= 1'b1;
        test_status_out <= 1'b0;
        icache_valid <= 1'b0;
        boot_done <= 1'b0;
        offchip_read <= 1'b0;
        srom_sel <= !sp_s2;
        // new settings only trusted after they hold steady long enough
        if (cfg_s2 != clk_cfg) begin
          clk_cfg <= cfg_s2;
          settle <= 8'h00;
          cfg_valid <= 1'b0;
        end else if (settle == `PRBS_CFG_SETTLE - 8'h01) begin
          cfg_valid <= 1'b1;
        end else begin
          settle <= settle + 8'h01;
        end
      end else begin
        case (state)
          S_RESET: begin
            state <= S_ICACHE_SELF_TEST;
            icache_self_test_start <= 1'b1;
          end
          S_ICACHE_SELF_TEST: begin
            cpu_reset <= 1'b1;
            if (icache_self_test_done && !icache_self_test_start && !icache_self_test_busy) begin
              icache_self_test_status <= icache_self_test_pass;
              test_status_out <= icache_self_test_pass;
              words <= 16'h0000;
              state <= srom_sel ? S_SROM : S_DISP;
            end
          end
          S_SROM: begin
            srom_oe_n <= 1'b0;
            srom_clk_out <= !srom_clk_out;
            if (srom_clk_out) begin
              if (words == SROM_WORDS[15:0] - 16'h0001) begin
                icache_valid <= 1'b1;
                srom_oe_n <= 1'b1;
                state <= S_DISP;
              end else begin
                words <= words + {15'h0000, sd_s2 | 1'b1};
              end
            end
          end
          S_DISP: begin
            cpu_reset <= 1'b0;
            srom_clk_out <= 1'b0;
            fetch_req <= 1'b1;
            fetch_addr <= `PRBS_RESET_VECTOR;
            offchip_read <= !icache_valid;
            // strobe low for one cycle marks the off-chip read command
            strobe_n <= icache_valid;
            state <= S_RUN;
          end
          S_RUN: begin
            boot_done <= 1'b1;
            bus_oe <= 1'b1;
            strobe_n <= 1'b1;
            if (offchip_read && fetch_hit_in) begin
              offchip_read <= 1'b0;
            end
          end
          default: begin
            state <= S_RESET;
          end
        endcase
        if (icache_flush_control) begin
          icache_valid <= 1'b0;
        end
      end
    end
  end
endmodule

/* prbs_board.sv */
// board power supervisor model: power good and system reset
module prbs_board #(
  parameter HOLD = 400
) (
  input wire clk_sys,
  input wire power_off,
  input wire pg_fail,
  output logic power_good_in,
  output logic sys_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    power_good_in = 1'b0;
    sys_reset_n = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (power_off) begin
      cnt <= 0;
      power_good_in <= 1'b0;
      sys_reset_n <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == 4) power_good_in <= 1'b1;
      if (pg_fail) power_good_in <= 1'b0;
      // release lands off the clock edge on purpose
      if (cnt == 4 + HOLD) sys_reset_n <= #7 1'b1;
    end
  end
endmodule

/* prbs_seq_assertions.sv */
// port checker for the reset and boot sequencer
module prbs_seq_checker (
  input logic clk_sys,
  input logic rst,
  input logic power_good_in,
  input logic sys_reset_n,
  input logic icache_flush_control,
  input logic cpu_reset,
  input logic use_ring_osc,
  input logic pins_weak_pull,
  input logic bus_oe,
  input logic strobe_n,
  input logic bus_clock_output_a,
  input logic bus_clock_output_b,
  input logic icache_valid,
  input logic fetch_req,
  input logic offchip_read,
  input logic [39:0] fetch_addr,
  input logic boot_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_pg_forces_reset:
    assert property (!power_good_in [*4] |-> cpu_reset)
    else $error("reset not forced");
  chk_osc_select:
    assert property ($stable(power_good_in) [*4]
      |-> use_ring_osc == !power_good_in) else $error("bad clock source");
  chk_weak_pull:
    assert property ((!power_good_in && !sys_reset_n) [*4]
      |-> pins_weak_pull && !bus_oe) else $error("pins not pulled");
  chk_reset_pins:
    assert property (cpu_reset |-> !bus_oe && strobe_n)
    else $error("pins active in reset");
  chk_bus_clock_runs:
    assert property (cpu_reset |-> ##[0:32] $changed(bus_clock_output_a))
    else $error("bus clock stopped");
  chk_bus_clock_b:
    assert property (cpu_reset |-> ##[0:32] $changed(bus_clock_output_b))
    else $error("second bus clock stopped");
  chk_dispatch_zero:
    assert property (fetch_req |-> fetch_addr == 40'h0 ##1 boot_done)
    else $error("bad dispatch");
  chk_miss_read:
    assert property (fetch_req |-> offchip_read == !icache_valid)
    else $error("miss read mismatch");
  chk_flush_clears:
    assert property (icache_flush_control && !cpu_reset |=> !icache_valid)
    else $error("flush ignored");
  chk_reset_thru_test:
    assert property (fetch_req |-> $past(cpu_reset))
    else $error("reset dropped early");
endmodule
bind prbs_sequencer prbs_seq_checker chk (.clk_sys(clk_sys), .rst(rst),
  .power_good_in(power_good_in), .sys_reset_n(sys_reset_n),
  .icache_flush_control(icache_flush_control), .cpu_reset(cpu_reset),
  .use_ring_osc(use_ring_osc), .pins_weak_pull(pins_weak_pull),
  .bus_oe(bus_oe), .strobe_n(strobe_n),
  .bus_clock_output_a(bus_clock_output_a),
  .bus_clock_output_b(bus_clock_output_b), .icache_valid(icache_valid),
  .fetch_req(fetch_req), .offchip_read(offchip_read),
  .fetch_addr(fetch_addr), .boot_done(boot_done));

/* tb.sv */
// self-checking bench for the reset and boot sequencer
`include "prbs_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, power_off, pg_fail, srom_n, flush, hit;
  logic [6:0] cfg;
  wire pg, rst_n, cpu_reset, ring, pull, freq, rd, ival, bdone, icache_self_test;
  wire boe, roe_n, rwe_n, stb_n, adv_n, tca, tcb, tcc, sclk, soe_n, tstat;
  wire cvalid;
  wire [6:0] ccfg;
  wire [39:0] faddr;
  // pins whose level in reset is fixed, most significant first
  wire [9:0] pin_state = {boe, roe_n, rwe_n, stb_n, adv_n, tca, tcb, tcc,
                          sclk, soe_n};
  int failures = 0;
  int srom_pulses = 0;
  int checks = 0;
  prbs_board board (.clk_sys(clk_sys), .power_off(power_off),
    .pg_fail(pg_fail), .power_good_in(pg), .sys_reset_n(rst_n));
  prbs_sequencer #(.ICACHE_SELF_TEST_CYCLES(8), .SROM_WORDS(4)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .power_good_in(pg),
    .sys_reset_n(rst_n), .irq_cfg_in(cfg), .srom_present_n(srom_n),
    .srom_data_in(1'b1), .icache_flush_control(flush),
    .fetch_hit_in(hit), .cpu_reset(cpu_reset), .use_ring_osc(ring),
    .pins_weak_pull(pull), .bus_oe(boe), .ram_oe_n(roe_n),
    .ram_we_n(rwe_n), .strobe_n(stb_n), .advance_n(adv_n),
    .test_clock_out_a(tca), .test_clock_out_b(tcb),
    .test_clock_out_c(tcc), .bus_clock_output_a(),
    .bus_clock_output_b(), .srom_clk_out(sclk), .srom_oe_n(soe_n),
    .test_status_out(tstat), .icache_self_test_status(icache_self_test),
    .clk_cfg(ccfg), .cfg_valid(cvalid), .icache_valid(ival),
    .fetch_req(freq),
    .offchip_read(rd), .fetch_addr(faddr), .boot_done(bdone));
  // serial ROM clock pulses as the far side would count them
  always @(posedge sclk) srom_pulses++;
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // power cycle, then wait for the reset dispatch
  task boot;
    int i;
    power_off = 1'b1;
    cyc(6);
    power_off = 1'b0;
    for (i = 0; freq !== 1'b1; i++) begin
      if (i > 700) begin
        failures++;
        tally_and_finish;
      end
      cyc(1);
    end
  endtask
  task t_cold_boot;
    srom_n = 1'b1;
    power_off = 1'b1;
    cyc(6);
    cmp(cpu_reset, 1);
    cmp(ring, 1);
    cmp(pull, 1);
    cmp(pin_state, 10'h1E1);
    cmp(tstat, 0);
    // new settings pass two sync flops and one capture before counting
    cfg = 7'h0B;
    cyc(3);
    cmp(ccfg, 7'h0B);
    cyc(`PRBS_CFG_SETTLE - 1);
    cmp(cvalid, 0);
    cyc(1);
    cmp(cvalid, 1);
    boot;
    cmp(faddr, 0);
    cmp(rd, 1);
    cmp(stb_n, 0);
    cmp(icache_self_test, 1);
    cmp(ring, 0);
    hit = 1'b1;
    cyc(1);
    hit = 1'b0;
    cmp(rd, 0);
    cmp(bdone, 1);
    cmp(tstat, 1);
    cmp(boe, 1);
    cmp(stb_n, 1);
    pg_fail = 1'b1;
    cyc(6);
    cmp(cpu_reset, 1);
    cmp(ring, 1);
    cmp(pin_state, 10'h1E1);
    pg_fail = 1'b0;
    $display("cold boot test done");
  endtask
  task t_srom_boot;
    srom_n = 1'b0;
    srom_pulses = 0;
    boot;
    cmp(ival, 1);
    cmp(rd, 0);
    cmp(stb_n, 1);
    cmp(srom_pulses, 4);
    cmp(soe_n, 1);
    cyc(2);
    flush = 1'b1;
    cyc(1);
    flush = 1'b0;
    cmp(ival, 0);
    $display("serial load test done");
  endtask
  initial begin
    rst = 1'b1;
    power_off = 1'b1;
    pg_fail = 1'b0;
    srom_n = 1'b1;
    cfg = 7'h02;
    flush = 1'b0;
    hit = 1'b0;
    cyc(3);
    rst = 1'b0;
    t_cold_boot;
    t_srom_boot;
    tally_and_finish;
  end
endmodule
